// ---- hdl/extremum_track.sv ----
// extremum tracker: finds signal maxima and minima with a noise gate
// assumes samples on mclk with a one-cycle valid strobe from the same domain
module extremum_track
    import hall_pkg::*;
#(
    parameter int W = SAMPLE_W
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                en,
    input  wire logic                smp_valid,
    input  wire logic signed [W-1:0] smp,
    input  wire logic signed [W-1:0] noise_constant_floor,
    output logic                     max_hit_q,
    output logic                     min_hit_q,
    output logic signed [W-1:0]      max_val_q,
    output logic signed [W-1:0]      min_val_q
);

    // ======================================================================
    // noise gate
    logic                seek_max_q;
    logic signed [W-1:0] peak_q;
    logic signed [W-1:0] trough_q;
    logic signed [W:0]   amp;
    logic signed [W:0]   quarter;
    logic signed [W:0]   floor_x;
    logic signed [W:0]   digital_noise_constant;
    logic signed [W:0]   drop;
    logic signed [W:0]   rise;

    // quarter of the last swing, never under the floor
    always_comb begin
        amp     = (W+1)'(max_val_q) - (W+1)'(min_val_q);
        quarter = amp >>> NOISE_SHIFT;
        floor_x = (W+1)'(noise_constant_floor);
        digital_noise_constant = (quarter > floor_x) ? quarter : floor_x;
        drop    = (W+1)'(peak_q) - (W+1)'(smp);
        rise    = (W+1)'(smp) - (W+1)'(trough_q);
    end

    // ======================================================================
    // peak and trough search, alternating
    always_ff @(posedge mclk) begin
        max_hit_q <= 1'b0;
        min_hit_q <= 1'b0;
        if (rst) begin
            seek_max_q <= 1'b1;
            peak_q     <= W'(THR_RST);
            trough_q   <= W'(THR_RST);
            max_val_q  <= W'(THR_RST);
            min_val_q  <= W'(THR_RST);
        end else if (!en) begin
            // idle tracking so the first swing starts from the live signal
            seek_max_q <= 1'b1;
            peak_q     <= smp;
            trough_q   <= smp;
        end else if (smp_valid) begin
            if (seek_max_q) begin
                if (smp > peak_q) begin
                    peak_q <= smp;
                end else if (drop > digital_noise_constant) begin
                    max_val_q  <= peak_q;          // tooth maximum
                    max_hit_q  <= 1'b1;
                    seek_max_q <= 1'b0;
                    trough_q   <= smp;
                end
            end else begin
                if (smp < trough_q) begin
                    trough_q <= smp;
                end else if (rise > digital_noise_constant) begin
                    min_val_q  <= trough_q;        // notch minimum
                    min_hit_q  <= 1'b1;
                    seek_max_q <= 1'b1;
                    peak_q     <= smp;
                end
            end
        end
    end

    // ======================================================================
    // checks
    swing_gate_a: assert property (@(posedge mclk) disable iff (rst)
        max_hit_q |-> $past(drop) > $past(digital_noise_constant))
        else $error("maximum accepted below noise constant");

    min_gate_a: assert property (@(posedge mclk) disable iff (rst)
        min_hit_q |-> $past(rise) > $past(digital_noise_constant))
        else $error("minimum accepted below noise constant");

endmodule // extremum_track

// ---- hdl/hall_switch_phase_control.sv ----
// switching core of a programmable tooth/notch magnetic sensor
// assumes samples, nonvolatile contents and settings arrive on mclk
//
// Contract
// - default: tooth pulls output low, notch releases it high
// - programmed polarity inverts field to output relation
// - phases: initial, then precalibrated, then calibrated
// - initial phase compares each sample with threshold to set output
// - initial comparison carries hysteresis against noise
// - initial threshold comes from rewritable nonvolatile register
// - factory-only memory: search present field, load it as threshold
// - customer-programmed memory: switch output against stored threshold
// - memory failure: output released about 2.6 ms, then held low
// - after initial phase, precalibrated phase monitors the signal
// - precalibrated phase detects minima and maxima
// - extremum accepted only beyond quarter amplitude, never under floor
// - raise offset only at falling edges, lower only at rising edges
// - after programmed switch count, enter calibrated phase
// - every power up restarts in initial phase
module hall_switch_phase_control
    import hall_pkg::*;
#(
    parameter int W               = SAMPLE_W,
    parameter int HYST            = HYST_DEF,
    parameter int FAIL_HIZ_CYCLES = FAIL_HIZ_CYC
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic                sample_valid,
    input  wire logic signed [W-1:0] sample,
    input  wire logic signed [W-1:0] power_on_threshold,
    input  wire logic                nvm_customer,
    input  wire logic                nvm_fail,
    input  wire logic                polarity_inv,
    input  wire logic [SW_CNT_W-1:0] switch_target,
    input  wire logic signed [W-1:0] noise_constant_floor,
    output logic                     q_out_q,
    output logic                     q_oe_q,
    output phase_t                   phase_q,
    output logic signed [W-1:0]      threshold_q,
    output logic                     programmed_q
);

    // ======================================================================
    // declarations
    localparam int FW = $clog2(FAIL_HIZ_CYCLES + 1);

    logic [FW-1:0]        fail_cnt_q;
    logic [SW_CNT_W-1:0]  sw_cnt_q;
    logic                 tooth_q;
    logic                 tooth_d;
    logic                 seen_max_q;
    logic                 seen_min_q;
    logic                 cmp_phase;
    logic                 track_en;
    logic                 above;
    logic                 below;
    logic signed [W:0]    hyst_x;
    logic signed [W:0]    smp_x;
    logic signed [W:0]    thr_x;
    logic signed [W:0]    mid_x;
    logic signed [W-1:0]  target;
    logic                 max_hit;
    logic                 min_hit;
    logic signed [W-1:0]  max_val;
    logic signed [W-1:0]  min_val;

    // ======================================================================
    // extremum tracking runs once the initial phase is over
    assign track_en = (phase_q == ST_PRECAL) || (phase_q == ST_CAL);

    extremum_track #(
        .W                    (W)
    ) u_track (
        .mclk                 (mclk),
        .rst                  (rst),
        .en                   (track_en),
        .smp_valid            (sample_valid),
        .smp                  (sample),
        .noise_constant_floor (noise_constant_floor),
        .max_hit_q            (max_hit),
        .min_hit_q            (min_hit),
        .max_val_q            (max_val),
        .min_val_q            (min_val)
    );

    // ======================================================================
    // comparison against threshold, signed, with a band around it
    // the calibrated phase drops the visible band for best accuracy
    always_comb begin
        cmp_phase = (phase_q == ST_INIT) || track_en;
        hyst_x    = (phase_q == ST_CAL) ? '0 : (W+1)'(HYST);
        smp_x     = (W+1)'(sample);
        thr_x     = (W+1)'(threshold_q);
        above     = smp_x > (thr_x + hyst_x);
        below     = smp_x < (thr_x - hyst_x);
        tooth_d   = above ? 1'b1 : (below ? 1'b0 : tooth_q);
        mid_x     = ((W+1)'(max_val) + (W+1)'(min_val)) >>> 1;
        target    = mid_x[W-1:0];
    end

    // ======================================================================
    // phase sequencer; reset always lands in evaluation
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_q <= ST_EVAL;
        end else begin
            case (phase_q)
                ST_EVAL: begin
                    // memory flags read once, here only
                    if (nvm_fail) begin
                        phase_q <= ST_FAIL_HIZ;
                    end else if (nvm_customer) begin
                        phase_q <= ST_INIT;
                    end else begin
                        phase_q <= ST_SEARCH;
                    end
                end
                ST_SEARCH: begin
                    if (sample_valid) begin
                        phase_q <= ST_INIT;
                    end
                end
                ST_FAIL_HIZ: begin
                    if (fail_cnt_q == FW'(FAIL_HIZ_CYCLES - 1)) begin
                        phase_q <= ST_FAIL_LOW;
                    end
                end
                ST_FAIL_LOW: begin
                    phase_q <= ST_FAIL_LOW;                    // locked until power cycle
                end
                ST_INIT: begin
                    if (sample_valid) begin
                        phase_q <= ST_PRECAL;
                    end
                end
                ST_PRECAL: begin
                    if (switch_target != '0 && sw_cnt_q >= switch_target) begin
                        phase_q <= ST_CAL;
                    end
                end
                ST_CAL: begin
                    phase_q <= ST_CAL;
                end
                default: begin
                    phase_q <= ST_EVAL;
                end
            endcase
        end
    end

    // ======================================================================
    // programmed flag, latched in evaluation
    always_ff @(posedge mclk) begin
        if (rst) begin
            programmed_q <= 1'b0;
        end else if (phase_q == ST_EVAL) begin
            programmed_q <= nvm_customer;
        end
    end

    // ======================================================================
    // released-output timer after a memory failure
    always_ff @(posedge mclk) begin
        if (rst) begin
            fail_cnt_q <= '0;
        end else if (phase_q == ST_FAIL_HIZ) begin
            fail_cnt_q <= fail_cnt_q + FW'(1);
        end else begin
            fail_cnt_q <= '0;
        end
    end

    // ======================================================================
    // threshold: stored value, searched value, then edge-gated updates
    // a raise only at a maximum, so the output never double switches
    always_ff @(posedge mclk) begin
        if (rst) begin
            threshold_q <= W'(THR_RST);
        end else begin
            case (phase_q)
                ST_EVAL: begin
                    if (nvm_customer) begin
                        threshold_q <= power_on_threshold;
                    end
                end
                ST_SEARCH: begin
                    if (sample_valid) begin
                        threshold_q <= sample;
                    end
                end
                ST_INIT: begin
                    if (programmed_q) begin
                        threshold_q <= power_on_threshold;
                    end
                end
                ST_PRECAL: begin
                    if (max_hit && seen_min_q && target > threshold_q) begin
                        threshold_q <= target;
                    end else if (min_hit && seen_max_q && target < threshold_q) begin
                        threshold_q <= target;
                    end
                end
                ST_CAL: begin
                    // minor corrections only: one LSB per extremum
                    if (max_hit && target > threshold_q) begin
                        threshold_q <= threshold_q + W'(1);
                    end else if (min_hit && target < threshold_q) begin
                        threshold_q <= threshold_q - W'(1);
                    end
                end
                default: begin
                    threshold_q <= threshold_q;
                end
            endcase
        end
    end

    // ======================================================================
    // a pair is complete once both kinds of extremum were seen
    always_ff @(posedge mclk) begin
        if (rst || !track_en) begin
            seen_max_q <= 1'b0;
            seen_min_q <= 1'b0;
        end else begin
            if (max_hit) seen_max_q <= 1'b1;
            if (min_hit) seen_min_q <= 1'b1;
        end
    end

    // ======================================================================
    // magnetic state and open-drain drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            tooth_q <= 1'b0;
            q_oe_q  <= 1'b0;
            q_out_q <= 1'b0;
        end else begin
            q_out_q <= 1'b0;                                   // drain pulls low only
            if (phase_q == ST_FAIL_LOW) begin
                q_oe_q <= 1'b1;
            end else if (cmp_phase) begin
                if (sample_valid) begin
                    tooth_q <= tooth_d;
                    q_oe_q  <= tooth_d ^ polarity_inv;
                end
            end else begin
                q_oe_q <= 1'b0;                                // released while not decided
            end
        end
    end

    // ======================================================================
    // output switch events, counted in the precalibrated phase
    always_ff @(posedge mclk) begin
        if (rst || phase_q != ST_PRECAL) begin
            sw_cnt_q <= SW_CNT_W'(SW_CNT_RST);
        end else if (sample_valid && (tooth_d != tooth_q) && (sw_cnt_q != '1)) begin
            sw_cnt_q <= sw_cnt_q + SW_CNT_W'(1);
        end
    end

    // ======================================================================
    // checks
    tooth_low_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && cmp_phase && above && !polarity_inv) |=> q_oe_q)
        else $error("tooth did not pull output low");

    notch_high_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && cmp_phase && below && !polarity_inv) |=> !q_oe_q)
        else $error("notch did not release output");

    polarity_swap_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && cmp_phase && above && polarity_inv) |=> !q_oe_q)
        else $error("inverted polarity not applied");

    hyst_hold_a: assert property (@(posedge mclk) disable iff (rst)
        (sample_valid && cmp_phase && !above && !below && !polarity_inv)
        |=> q_oe_q == $past(tooth_q))
        else $error("output moved inside hysteresis band");

    search_load_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_SEARCH && sample_valid)
        |=> threshold_q == $past(sample) && phase_q == ST_INIT)
        else $error("searched value not loaded");

    stored_load_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_EVAL && nvm_customer && !nvm_fail)
        |=> threshold_q == $past(power_on_threshold) && phase_q == ST_INIT)
        else $error("stored threshold not used");

    fail_hiz_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_EVAL && nvm_fail) ##1 (phase_q == ST_FAIL_HIZ)[*8]
        |-> !q_oe_q)
        else $error("output driven during failure release time");

    fail_low_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_FAIL_LOW) |=> q_oe_q && phase_q == ST_FAIL_LOW)
        else $error("failure did not lock output low");

    precal_next_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_INIT && sample_valid) |=> phase_q == ST_PRECAL)
        else $error("precalibrated phase not entered");

    cal_entry_a: assert property (@(posedge mclk) disable iff (rst)
        (phase_q == ST_PRECAL && switch_target != '0 && sw_cnt_q >= switch_target)
        |=> phase_q == ST_CAL)
        else $error("calibrated phase not entered");

    raise_edge_a: assert property (@(posedge mclk) disable iff (rst)
        (track_en ##1 threshold_q > $past(threshold_q)) |-> $past(max_hit))
        else $error("threshold raised away from falling edge");

    power_up_a: assert property (@(posedge mclk)
        rst |=> phase_q == ST_EVAL)
        else $error("reset did not restart phases");

    cal_reached_c: cover property (@(posedge mclk) disable iff (rst)
        phase_q == ST_PRECAL ##1 phase_q == ST_CAL);
    fail_locked_c: cover property (@(posedge mclk) disable iff (rst)
        phase_q == ST_FAIL_HIZ ##1 phase_q == ST_FAIL_LOW);
    search_done_c: cover property (@(posedge mclk) disable iff (rst)
        phase_q == ST_SEARCH ##1 phase_q == ST_INIT);
    pair_update_c: cover property (@(posedge mclk) disable iff (rst)
        phase_q == ST_PRECAL && min_hit && seen_max_q);

endmodule // hall_switch_phase_control

// ---- pkg/hall_pkg.sv ----
// constants and phase type shared by the switching core and its extremum tracker
// assumes one 100 MHz clock and signed magnetic samples from the chopped amplifier
package hall_pkg;

    // ======================================================================
    // widths and defaults
    localparam int SAMPLE_W      = 12;   // magnetic sample width
    localparam int HYST_DEF      = 8;    // hysteresis half band, in LSB
    localparam int SW_CNT_W      = 7;    // switch event count, up to 127
    localparam int NOISE_SHIFT   = 2;    // quarter of the amplitude
    localparam int THR_RST       = 0;    // threshold after reset
    localparam int SW_CNT_RST    = 0;    // switch count after reset

    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int FAIL_HIZ_NS   = 2_600_000;   // 2.6 ms released output
    localparam int FAIL_HIZ_CYC  = FAIL_HIZ_NS / CLK_PERIOD_NS;

    // ======================================================================
    // operating phases
    typedef enum logic [2:0] {
        ST_EVAL,
        ST_SEARCH,
        ST_FAIL_HIZ,
        ST_FAIL_LOW,
        ST_INIT,
        ST_PRECAL,
        ST_CAL
    } phase_t;

endpackage

// ---- verification/od_reader.sv ----
// open-drain pin reader standing in for the controller on the switch line
// assumes a pull-up on the line and a drain enable that is high while pulling low
module od_reader (
    input  wire logic q_out_q,
    input  wire logic q_oe_q,
    output logic      pin_level
);
    timeunit 1ns;
    timeprecision 1ps;

    // ======================================================================
    // pin resolution
    // a released line goes to the pull-up level, so no stale value can linger
    assign pin_level = q_oe_q ? q_out_q : 1'b1;
endmodule // od_reader

// ---- verification/test_hall_switch_phase_control.sv ----
// self-checking bench for the tooth/notch switching core
// assumes the phase package and the open-drain reader model are compiled first
module test_hall_switch_phase_control;
    timeunit 1ns;
    timeprecision 1ps;
    import hall_pkg::*;

    localparam int HIZ = 20;    // shortened failure hold, keeps the run brief
    localparam int TMO = 4000;  // whole run needs well under this

    logic                       mclk, rst, sample_valid, nvm_customer, nvm_fail, polarity_inv;
    logic signed [SAMPLE_W-1:0] sample, power_on_threshold, noise_constant_floor, threshold_q, thr, s;
    logic [SW_CNT_W-1:0]        switch_target;
    logic                       q_out_q, q_oe_q, programmed_q, pin_level, tooth;
    phase_t                     phase_q;
    int                         n_errors, compares, cycles, d;
    integer                     seed;

    hall_switch_phase_control #(.W(SAMPLE_W), .HYST(HYST_DEF), .FAIL_HIZ_CYCLES(HIZ)) dut (
        .mclk(mclk), .rst(rst), .sample_valid(sample_valid), .sample(sample),
        .power_on_threshold(power_on_threshold), .nvm_customer(nvm_customer), .nvm_fail(nvm_fail),
        .polarity_inv(polarity_inv), .switch_target(switch_target),
        .noise_constant_floor(noise_constant_floor), .q_out_q(q_out_q), .q_oe_q(q_oe_q),
        .phase_q(phase_q), .threshold_q(threshold_q), .programmed_q(programmed_q));

    od_reader reader (.q_out_q(q_out_q), .q_oe_q(q_oe_q), .pin_level(pin_level));

    // ======================================================================
    // clock and hang guard
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // a hang counts as a mismatch and still ends in the closing report
    always @(posedge mclk) begin
        cycles++;
        if (cycles > TMO) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ======================================================================
    // shared tasks and expectations
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // settings must be steady before release: the memory flags are sampled once, just after it
    task automatic do_reset(input logic cust, input logic fail, input logic pol, input int t);
        nvm_customer = cust;
        nvm_fail = fail;
        polarity_inv = pol;
        power_on_threshold = SAMPLE_W'(t);
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        check("reset phase", ST_EVAL, phase_q);
        check("reset pin", 1'b1, pin_level);
        repeat (2) @(posedge mclk);
        #1;
    endtask

    // one-cycle valid strobe; returns once the answer has landed
    task automatic send(input int v);
        @(posedge mclk);
        #1 sample = SAMPLE_W'(v);
        sample_valid = 1'b1;
        @(posedge mclk);
        #1 sample_valid = 1'b0;
    endtask

    // tooth pulls the pin low unless polarity is inverted
    function automatic logic exp_pin(input logic t, input logic pol);
        return (t ^ pol) ? 1'b0 : 1'b1;
    endfunction

    // switching level sits halfway between the accepted maximum and minimum
    function automatic int mid_of(input int hi, input int lo);
        return (hi + lo) >>> 1;
    endfunction

    // ======================================================================
    // main sequence
    initial begin
        seed = 32'hAE145E70;
        rst = 1'b1;
        sample_valid = 1'b0;
        sample = 12'h000;
        nvm_customer = 1'b1;
        nvm_fail = 1'b0;
        polarity_inv = 1'b0;
        power_on_threshold = 12'h000;
        switch_target = 7'h00;
        // floor far above the test swings, so the threshold must stay put
        noise_constant_floor = 12'h3E8;
        // customer threshold, both polarities, random level and hysteresis sweep
        for (int i = 0; i < 8; i++) begin
            thr = SAMPLE_W'($random(seed) % 256);
            d = HYST_DEF + 1 + ($random(seed) & 32'h3F);
            do_reset(1'b1, 1'b0, i[0], int'(thr));
            check("phase init", ST_INIT, phase_q);
            check("programmed", 1'b1, programmed_q);
            check("thr loaded", thr, threshold_q);
            send(thr + d);
            check("pin tooth", exp_pin(1'b1, i[0]), pin_level);
            check("phase precal", ST_PRECAL, phase_q);
            send(thr + HYST_DEF);
            check("hold upper", exp_pin(1'b1, i[0]), pin_level);
            send(thr - HYST_DEF);
            check("hold lower", exp_pin(1'b1, i[0]), pin_level);
            send(thr - d);
            check("pin notch", exp_pin(1'b0, i[0]), pin_level);
            tooth = 1'b0;
            for (int k = 0; k < 16; k++) begin
                s = SAMPLE_W'(thr + ($random(seed) % 24));
                send(s);
                if (s > thr + HYST_DEF) begin
                    tooth = 1'b1;
                end else if (s < thr - HYST_DEF) begin
                    tooth = 1'b0;
                end
                check("random pin", exp_pin(tooth, i[0]), pin_level);
            end
            check("thr kept", thr, threshold_q);
            $display("customer test %0d done", i);
        end
        // factory-only memory: first sample becomes the threshold
        for (int i = 0; i < 2; i++) begin
            thr = SAMPLE_W'($random(seed) % 512);
            do_reset(1'b0, 1'b0, 1'b0, 32'h123);
            check("phase search", ST_SEARCH, phase_q);
            check("factory flag", 1'b0, programmed_q);
            check("search pin", 1'b1, pin_level);
            send(thr);
            check("thr searched", thr, threshold_q);
            check("phase init2", ST_INIT, phase_q);
            send(thr + HYST_DEF + 1);
            check("search tooth", 1'b0, pin_level);
            $display("factory test %0d done", i);
        end
        // memory failure: released for the hold time, then stuck low
        do_reset(1'b1, 1'b1, 1'b0, 0);
        check("fail phase", ST_FAIL_HIZ, phase_q);
        send(12'h400);
        repeat (HIZ - 6) @(posedge mclk);
        #1 check("fail released", 1'b1, pin_level);
        repeat (8) @(posedge mclk);
        #1 check("fail low", 1'b0, pin_level);
        send(-400);
        check("fail stuck", 1'b0, pin_level);
        check("fail final", ST_FAIL_LOW, phase_q);
        $display("failure test done");
        // three switch events lead into the calibrated phase
        switch_target = 7'h03;
        do_reset(1'b1, 1'b0, 1'b0, 0);
        send(50);
        send(-50);
        send(50);
        check("not yet cal", ST_PRECAL, phase_q);
        send(-50);
        @(posedge mclk);
        #1 check("phase cal", ST_CAL, phase_q);
        // power up again from mid-run goes back to the initial phase
        do_reset(1'b1, 1'b0, 1'b0, 0);
        check("restart init", ST_INIT, phase_q);
        $display("phase test done");
        // low floor: a full swing pulls the threshold to the midpoint, at a falling edge only
        noise_constant_floor = 12'h010;
        switch_target = 7'h00;
        send(100);
        send(200);
        send(150);
        send(-100);
        check("max without min", 0, threshold_q);
        send(0);
        @(posedge mclk);
        #1 check("no raise at rise", 0, threshold_q);
        send(250);
        send(100);
        @(posedge mclk);
        #1 check("thr midpoint", mid_of(250, -100), threshold_q);
        send(60);
        check("pin new thr", 1'b1, pin_level);
        $display("extremum test done");
        tally_and_finish();
    end
endmodule // test_hall_switch_phase_control
